/* File: rtl/bms_decoder.sv */
// Purpose: Captures and decodes the serial boot mode stream
// Assumes: Source changes data while the mode clock is low
// Notes:   Bits are sampled on each mode clock rising edge while capturing
`include "bms_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module bms_decoder
  import bms_pkg::*;
#(
  parameter int STREAM_LEN = `BMS_STREAM_LEN,
  parameter int MCLK_DIV   = `BMS_MCLK_DIV
) (
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      rst,
  // Power and serial stream
  input  wire logic      supply_good,
  input  wire logic      mode_serial_in,
  output logic           mode_serial_clock,
  // Decoded configuration
  output var bms_cfg_s   cfg_out,
  output logic           cfg_valid,
  output logic           cfg_code_err,
  output logic           cfg_bit_err
);

  if (STREAM_LEN <= `BMS_POS_DRV_HI + 1 || STREAM_LEN > 256) begin : g_bad_len
    $error("bms_decoder: STREAM_LEN must lie in 16..256");
  end

  if (MCLK_DIV > 256) begin : g_bad_div
    $error("bms_decoder: MCLK_DIV must not exceed 256");
  end

  bms_dec_s q;
  bms_dec_s d;
  logic     sample_en;
  logic     mclk_q;
  logic     start;

  // ----------------------------------------------------------------
  // Mode clock
  // ----------------------------------------------------------------
  bms_mclk_div #(
    .DIV (MCLK_DIV)
  ) u_div (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .mclk       (mclk_q),
    .rise_pulse (sample_en)
  );

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  function automatic bms_cfg_s decode(input logic [14:0] b);
    bms_cfg_s c;
    c             = '0;
    c.wb_code     = b[`BMS_POS_WB_HI:`BMS_POS_WB_LO]; // see [RULE_02]
    if (b[`BMS_POS_MULT_HI:`BMS_POS_MULT_LO] == `BMS_MULT_RSVD) begin
      c.clk_mult = 4'h0;
    end else begin
      c.clk_mult = {1'b0, b[`BMS_POS_MULT_HI:`BMS_POS_MULT_LO]} + `BMS_MULT_OFS; // see [RULE_03]
    end
    c.big_endian    = b[`BMS_POS_ENDIAN]; // see [RULE_04]
    c.write_proto   = bms_wproto_e'(b[`BMS_POS_WP_HI:`BMS_POS_WP_LO]); // see [RULE_05]
    c.timer_int_off = b[`BMS_POS_TIMER]; // see [RULE_06]
    c.bus_32        = b[`BMS_POS_WIDTH]; // see [RULE_07]
    c.drive_code    = b[`BMS_POS_DRV_HI:`BMS_POS_DRV_LO]; // see [RULE_08]
    case (c.drive_code)
      `BMS_DRV_FULL: c.drive_pct = `BMS_PCT_FULL;
      `BMS_DRV_83:   c.drive_pct = `BMS_PCT_83;
      `BMS_DRV_67:   c.drive_pct = `BMS_PCT_67;
      default:       c.drive_pct = `BMS_PCT_50;
    endcase
    return c;
  endfunction

  function automatic logic code_bad(input logic [14:0] b);
    logic bad;
    bad = (b[`BMS_POS_WB_HI:`BMS_POS_WB_LO] > `BMS_WB_MAX)
        | (b[`BMS_POS_MULT_HI:`BMS_POS_MULT_LO] == `BMS_MULT_RSVD)
        | (b[`BMS_POS_WP_HI:`BMS_POS_WP_LO] == BMS_WP_RESERVED);
    return bad;
  endfunction

  // ----------------------------------------------------------------
  // Capture sequence
  // ----------------------------------------------------------------
  always_comb begin
    d     = q;
    d.sg  = supply_good;
    start = supply_good & ~q.sg;
    case (q.state)
      BMS_IDLE: begin
        d.state = BMS_IDLE;
      end
      BMS_CAPTURE: begin
        if (sample_en) begin
          if (q.cnt < 8'(`BMS_POS_RSVD_LO)) begin
            d.bits[q.cnt[3:0]] = mode_serial_in; // see [RULE_10]
          end else if (mode_serial_in) begin
            d.rsvd_bit = 1'b1; // see [RULE_01]
          end
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == 8'(STREAM_LEN - 1)) begin
            d.state    = BMS_DONE; // see [RULE_09]
            d.valid    = 1'b1; // see [RULE_13]
            d.cfg      = decode(d.bits);
            d.code_err = code_bad(d.bits);
            d.bit_err  = d.rsvd_bit | d.bits[`BMS_POS_RSVD0]; // see [RULE_01]
          end
        end
      end
      BMS_DONE: begin
        d.state = BMS_DONE; // see [RULE_12]
      end
      default: begin
        d.state = BMS_IDLE;
      end
    endcase
    if (start) begin
      d.state    = BMS_CAPTURE; // see [RULE_09]
      d.cnt      = 8'h00;
      d.bits     = 15'h0000;
      d.rsvd_bit = 1'b0;
      d.valid    = 1'b0; // see [RULE_13]
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mode_serial_clock = mclk_q; // see [RULE_12]
  assign cfg_out           = q.cfg;
  assign cfg_valid         = q.valid;
  assign cfg_code_err      = q.code_err;
  assign cfg_bit_err       = q.bit_err;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic       mclk_prev_q;
  logic [8:0] phase_len_q;

  // Cycles spent in the current mode clock phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mclk_prev_q <= 1'b0;
      phase_len_q <= 9'h000;
    end else begin
      mclk_prev_q <= mode_serial_clock;
      if (mode_serial_clock != mclk_prev_q) begin
        phase_len_q <= 9'h001;
      end else begin
        phase_len_q <= phase_len_q + 9'h001;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_mclk_phase: assert property (mode_serial_clock != mclk_prev_q |-> // see [RULE_11]
      phase_len_q == 9'(MCLK_DIV / 2))
    else $error("mode clock phase length wrong");
  a_mclk_running: assert property (phase_len_q <= 9'(MCLK_DIV / 2)) // see [RULE_12]
    else $error("mode clock stopped");
  a_sample_edge: assert property (sample_en |-> // see [RULE_10]
      mode_serial_clock && !mclk_prev_q)
    else $error("bit sampled off the mode clock rise");
  a_count_step: assert property (q.state == BMS_CAPTURE && sample_en && !start |=> // see [RULE_09]
      q.cnt == $past(q.cnt) + 8'h01)
    else $error("position counter skipped");
  a_code_flag: assert property (cfg_valid |-> cfg_code_err == // see [RULE_02]
      ((q.bits[4:1] > 4'h8) || (q.bits[7:5] == 3'h7) || (q.bits[10:9] == 2'h1)))
    else $error("reserved code flag wrong");
  a_drive_slow: assert property (cfg_valid && q.bits[14:13] == 2'h1 |-> // see [RULE_08]
      cfg_out.drive_pct == 7'h32)
    else $error("slow drive strength decode wrong");

  a_valid_clears: assert property ($rose(supply_good) |=> !cfg_valid) // see [RULE_13]
    else $error("valid not cleared at supply-good");
  a_cfg_holds: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg_out)) // see [RULE_13]
    else $error("configuration changed while valid");
  a_valid_count: assert property ($rose(cfg_valid) |-> // see [RULE_09]
      $past(q.cnt) == 8'(STREAM_LEN - 1) && $past(sample_en))
    else $error("valid raised before last bit");
  a_done_frozen: assert property (q.state == BMS_DONE && !start |=> $stable(q.cnt)) // see [RULE_12]
    else $error("sampling continued after stream");
  a_mult_value: assert property (cfg_valid |->
      cfg_out.clk_mult == ((q.bits[7:5] == 3'h7) ? 4'h0 : {1'b0, q.bits[7:5]} + 4'h2)) // see [RULE_03]
    else $error("multiplier decode wrong");
  a_wb_code: assert property (cfg_valid |-> cfg_out.wb_code == q.bits[4:1]) // see [RULE_02]
    else $error("writeback pattern decode wrong");
  a_endian_bit: assert property (cfg_valid |-> cfg_out.big_endian == q.bits[8]) // see [RULE_04]
    else $error("endian decode wrong");
  a_wp_field: assert property (cfg_valid |-> cfg_out.write_proto == q.bits[10:9]) // see [RULE_05]
    else $error("write protocol decode wrong");
  a_timer_width: assert property (cfg_valid |->
      cfg_out.timer_int_off == q.bits[11] && cfg_out.bus_32 == q.bits[12]) // see [RULE_06]
    else $error("timer or width decode wrong");
  a_drive_pct: assert property (cfg_valid && q.bits[14:13] == 2'h2 |->
      cfg_out.drive_pct == 7'h64) // see [RULE_08]
    else $error("drive strength decode wrong");
  a_rsvd_flag: assert property (cfg_valid && q.bits[0] |-> cfg_bit_err) // see [RULE_01]
    else $error("reserved bit not flagged");

  c_start: cover property ($rose(supply_good));
  c_valid: cover property ($rose(cfg_valid));
  c_bit_err: cover property ($rose(cfg_valid) && cfg_bit_err);
  c_restart: cover property (q.state == BMS_CAPTURE && start);
  c_code_err: cover property ($rose(cfg_valid) && cfg_code_err);

endmodule // bms_decoder
`default_nettype wire

/* File: pkg/bms_cfg.svh */
// Purpose: Constants of the boot mode stream decoder
// Assumes: Reference clock of 100 MHz drives clk_sys
// Notes:   Bit positions count from stream position 0
//
// Summary of operation
// [RULE_01] Source sends zero at positions 0, 15-255
// [RULE_02] Bits 4:1 pick writeback pattern, 9-15 reserved
// [RULE_03] Bits 7:5 give multiplier code plus two
// [RULE_04] Bit 8 one means big endian
// [RULE_05] Bits 10:9 pick write protocol, 01 reserved
// [RULE_06] Bit 11 suppresses timer interrupt on line 5
// [RULE_07] Bit 12 one selects 32-bit multiplexed bus
// [RULE_08] Bits 14:13 pick output driver strength
// [RULE_09] Read exactly 256 bits after supply-good
// [RULE_10] Position 0 first at supply-good, 255 last
// [RULE_11] Mode clock is reference clock divided by 256
// [RULE_12] Mode clock keeps running, no further sampling
// [RULE_13] Outputs hold until next supply-good; valid flag
`ifndef BMS_CFG_SVH
`define BMS_CFG_SVH

// ----------------------------------------------------------------
// Stream layout
// ----------------------------------------------------------------
`define BMS_POS_RSVD0     0
`define BMS_POS_WB_LO     1
`define BMS_POS_WB_HI     4
`define BMS_POS_MULT_LO   5
`define BMS_POS_MULT_HI   7
`define BMS_POS_ENDIAN    8
`define BMS_POS_WP_LO     9
`define BMS_POS_WP_HI     10
`define BMS_POS_TIMER     11
`define BMS_POS_WIDTH     12
`define BMS_POS_DRV_LO    13
`define BMS_POS_DRV_HI    14
`define BMS_POS_RSVD_LO   15
`define BMS_STREAM_LEN    256

// ----------------------------------------------------------------
// Codes and values
// ----------------------------------------------------------------
`define BMS_WB_MAX        4'h8
`define BMS_MULT_OFS      4'h2
`define BMS_MULT_RSVD     3'h7
`define BMS_DRV_FULL      2'h2
`define BMS_DRV_83        2'h3
`define BMS_DRV_67        2'h0
`define BMS_DRV_50        2'h1
`define BMS_PCT_FULL      7'h64
`define BMS_PCT_83        7'h53
`define BMS_PCT_67        7'h43
`define BMS_PCT_50        7'h32

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BMS_CLK_PERIOD_NS   10
`define BMS_MCLK_PERIOD_NS  2560
`define BMS_MCLK_DIV        (`BMS_MCLK_PERIOD_NS / `BMS_CLK_PERIOD_NS)

`endif

/* File: pkg/bms_pkg.sv */
// Purpose: Types of the boot mode stream decoder
// Assumes: Nothing
// Notes:   Constants live in bms_cfg.svh
package bms_pkg;

  typedef enum logic [1:0] {
    BMS_WP_LEGACY    = 2'h0,
    BMS_WP_RESERVED  = 2'h1,
    BMS_WP_PIPELINED = 2'h2,
    BMS_WP_REISSUE   = 2'h3
  } bms_wproto_e;

  typedef enum logic [1:0] {
    BMS_IDLE,
    BMS_CAPTURE,
    BMS_DONE
  } bms_state_e;

  typedef struct packed {
    logic [3:0]  wb_code;
    logic [3:0]  clk_mult;
    logic        big_endian;
    bms_wproto_e write_proto;
    logic        timer_int_off;
    logic        bus_32;
    logic [1:0]  drive_code;
    logic [6:0]  drive_pct;
  } bms_cfg_s;

  typedef struct packed {
    bms_state_e  state;
    logic        sg;
    logic [7:0]  cnt;
    logic [14:0] bits;
    logic        rsvd_bit;
    logic        valid;
    logic        code_err;
    logic        bit_err;
    bms_cfg_s    cfg;
  } bms_dec_s;

endpackage

/* File: rtl/bms_mclk_div.sv */
// Purpose: Free-running divider making the serial mode clock
// Assumes: DIV even; output high in the second half of a period
// Notes:   rise_pulse marks the cycle the clock goes high
`timescale 1ns/100ps
`default_nettype none
module bms_mclk_div #(
  parameter int DIV = 256
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Divided clock
  output logic      mclk,
  output logic      rise_pulse
);
  localparam int W = $clog2(DIV);

  if (DIV < 2 || (DIV % 2) != 0) begin : g_bad_div
    $error("bms_mclk_div: DIV must be even and at least 2");
  end

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         mclk;
    logic         rise;
  } bms_div_s;

  bms_div_s q;
  bms_div_s d;

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.cnt  = (q.cnt == W'(DIV - 1)) ? '0 : q.cnt + W'(1); // see [RULE_11]
    d.mclk = (d.cnt >= W'(DIV / 2));
    d.rise = d.mclk & ~q.mclk;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign mclk       = q.mclk;
  assign rise_pulse = q.rise;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Fixed 128-cycle halves only hold at the default ratio
  if (DIV == 256) begin : g_chk_256
    a_mclk_high_time: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_11]
        $rose(mclk) |-> ##128 $fell(mclk))
      else $error("mode clock high phase wrong");
    a_mclk_low_time: assert property (@(posedge clk_sys) disable iff (rst) // see [RULE_11]
        $fell(mclk) |-> ##128 $rose(mclk))
      else $error("mode clock low phase wrong");
  end

endmodule // bms_mclk_div
`default_nettype wire

/* File: test/bms_prom_model.sv */
// Purpose: Serial boot source feeding the mode stream
// Assumes: Data may change while the mode clock is low
// Notes:   After position 255 the line toggles each bit period
`timescale 1ns/100ps
`default_nettype none
module bms_prom_model (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Link
  input  wire logic         supply_good,
  input  wire logic         mode_serial_clock,
  output logic              mode_serial_in,
  // Stream contents
  input  wire logic [255:0] stream
);
  logic        sg_q;
  logic        mclk_q;
  logic        seen_q;
  logic [15:0] idx_q;

  // ----------------------------------------------------------------
  // Position counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sg_q   <= 1'b0;
      mclk_q <= 1'b0;
      seen_q <= 1'b0;
      idx_q  <= 16'h0;
    end else begin
      sg_q   <= supply_good;
      mclk_q <= mode_serial_clock;
      if (supply_good && !sg_q) begin
        idx_q  <= 16'h0;
        seen_q <= 1'b0;
      end else begin
        if (mode_serial_clock && !mclk_q)
          seen_q <= 1'b1;
        if (!mode_serial_clock && mclk_q && seen_q)
          idx_q <= idx_q + 16'h1;
      end
    end
  end

  // Reserved positions come from stream contents
  assign mode_serial_in = (idx_q < 16'h100) ? stream[idx_q[7:0]] : idx_q[0];
endmodule // bms_prom_model
`default_nettype wire

/* File: test/tb_top.sv */
// Purpose: Self-checking bench of the boot mode stream decoder
// Assumes: Mode clock divider shortened to 4
// Notes:   Rows first, then hand-written cases
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import bms_pkg::*;
;
  logic         clk_sys;
  logic         rst;
  logic         supply_good;
  logic         mode_serial_in;
  logic         mode_serial_clock;
  logic [255:0] stream;
  bms_cfg_s     cfg_out;
  logic         cfg_valid;
  logic         cfg_code_err;
  logic         cfg_bit_err;
  int           errors;
  int           checks_done;
  localparam logic [6:0]  PCT [4]   = '{7'h43, 7'h32, 7'h64, 7'h53};
  localparam logic [14:0] ROWS [11] = '{15'h0000, 15'h3b22, 15'h4444, 15'h7f66,
    15'h0088, 15'h2daa, 15'h56cc, 15'h61ee, 15'h0010, 15'h00fe, 15'h0001};

  // ----------------------------------------------------------------
  // Design and source
  // ----------------------------------------------------------------
  bms_decoder #(.STREAM_LEN(256), .MCLK_DIV(4)) dut (
    .clk_sys(clk_sys), .rst(rst), .supply_good(supply_good),
    .mode_serial_in(mode_serial_in), .mode_serial_clock(mode_serial_clock),
    .cfg_out(cfg_out), .cfg_valid(cfg_valid), .cfg_code_err(cfg_code_err),
    .cfg_bit_err(cfg_bit_err));
  bms_prom_model prom (
    .clk_sys(clk_sys), .rst(rst), .supply_good(supply_good),
    .mode_serial_clock(mode_serial_clock), .mode_serial_in(mode_serial_in),
    .stream(stream));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic bms_cfg_s exp_cfg(input logic [14:0] w);
    return '{w[4:1], (w[7:5] == 3'h7) ? 4'h0 : {1'b0, w[7:5]} + 4'h2, w[8],
             bms_wproto_e'(w[10:9]), w[11], w[12], w[14:13], PCT[w[14:13]]};
  endfunction

  function automatic logic code_err(input logic [14:0] w);
    return w[4:1] > 4'h8 || w[7:5] == 3'h7 || w[10:9] == 2'h1;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic run(input logic [255:0] s, input logic abort);
    int n;
    @(posedge clk_sys);
    stream      <= s;
    supply_good <= 1'b0;
    @(negedge clk_sys);
    n = 0;
    while (mode_serial_clock !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    while (mode_serial_clock !== 1'b0 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      errors++;
      wrap_up();
    end
    @(posedge clk_sys);
    supply_good <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(32'(cfg_valid), 32'h0);
    if (abort) begin
      repeat (40) @(negedge clk_sys);
      return;
    end
    n = 0;
    while (cfg_valid !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 2000) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic check_word(input logic [14:0] w, input logic hi);
    chk(32'(cfg_out), 32'(exp_cfg(w)));
    chk(32'({cfg_code_err, cfg_bit_err}), 32'({code_err(w), w[0] | hi}));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    int hi;
    int rises;
    logic prev;
    rst         = 1'b1;
    supply_good = 1'b0;
    stream      = '0;
    errors      = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    chk(32'({cfg_out, cfg_valid, cfg_code_err, cfg_bit_err, mode_serial_clock}), 32'h0);
    @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ROWS[i]) begin
      run({241'h0, ROWS[i]}, 1'b0);
      check_word(ROWS[i], 1'b0);
    end
    run({1'b1, 240'h0, 15'h3b22}, 1'b0);
    check_word(15'h3b22, 1'b1);
    run({240'h0, 1'b1, 15'h0}, 1'b0);
    check_word(15'h0, 1'b1);
    run({241'h0, 15'h7f66}, 1'b1);
    run({241'h0, 15'h2daa}, 1'b0);
    check_word(15'h2daa, 1'b0);
    hi    = 0;
    rises = 0;
    prev  = mode_serial_clock;
    repeat (64) begin
      @(negedge clk_sys);
      hi += int'(mode_serial_clock);
      rises += int'(mode_serial_clock && !prev);
      prev = mode_serial_clock;
    end
    chk(32'(hi), 32'd32);
    chk(32'(rises), 32'd16);
    chk(32'(cfg_valid), 32'h1);
    check_word(15'h2daa, 1'b0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
